// *** hdl/ehsec_core.sv ***
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
// ============================================================
module ehsec_core #(
  parameter int unsigned PROG_CYCLES   = ehsec_pkg::PROG_CYC,
  parameter bit          CFG_BYTE_ERASE = 1'b0
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // mode pins and mask option strap
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        sec_mask_option,
  // shared strobe pin and core strobe
  input  wire logic        strobe_in_or_addr_strobe_i,
  output logic             strobe_in_or_addr_strobe_o,
  output logic             strobe_in_or_addr_strobe_oe,
  input  wire logic        core_addr_strobe,
  output logic             strobe_a_capt,
  // state for the rest of the chip
  output logic [1:0]       op_mode,
  output logic             secure,
  output logic             boot_ready
);
  // ============================================================
  // declarations
  localparam int unsigned TMR_W_L = ehsec_pkg::TMR_W;
  localparam logic [TMR_W_L-1:0] TMR_END = TMR_W_L'(PROG_CYCLES - 1);
  localparam logic [ehsec_pkg::MEM_AW-1:0] WAD_END = ehsec_pkg::MEM_AW'(ehsec_pkg::MEM_DEPTH - 1);
  logic [7:0]             ctl_q, ctl_d;        // program control
  // eeprom cell: holds its value through reset, power-up content set here
  logic [7:0]             cfg_q = ehsec_pkg::CFG_RST;  // config byte
  logic [7:0]             cfg_d;               // config byte next value
  logic [7:0]             lat_q, lat_d;        // data latched for programming
  logic [TMR_W_L-1:0]     tmr_q, tmr_d;        // high voltage time
  logic [31:0]            prdata_q, prdata_d;  // read data
  logic                   rel_q, rel_d;        // reset released
  logic                   mask_q, mask_d;      // sampled mask option
  ehsec_pkg::ehsec_mode_t mode_q, mode_d;      // latched mode
  ehsec_pkg::ehsec_wipe_t wst_q, wst_d;        // wipe state
  logic [ehsec_pkg::MEM_AW-1:0] wad_q, wad_d;  // wipe address
  logic                   chk_q, chk_d;        // read data due for check
  logic                   bad_q, bad_d;        // mismatch seen this pass
  logic                   wr_acc, rd_set;      // apb phase strobes
  logic                   hv_on, hv_done;      // high voltage running, ending
  logic                   secure_live;         // security from current state
  logic                   mask_eff;            // mask option in force
  ehsec_pkg::ehsec_mode_t mode_live;           // mode decoded from pins
  logic                   tail_q, tail_d;      // verify waits on the last word

  ehsec_mem_if mif ();

  // mode decode, used live during reset and latched at release
  function automatic ehsec_pkg::ehsec_mode_t dec_mode(input logic b, input logic a, input logic sec);
    dec_mode = ehsec_pkg::ehsec_mode_t'({b, a & ~sec});
  endfunction : dec_mode

  // ============================================================
  // apb decode: zero wait states, unmapped address errors
  assign wr_acc  = psel & penable & pwrite;
  assign rd_set  = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != ehsec_pkg::CTL_ADDR) & (paddr != ehsec_pkg::CFG_ADDR)
                   & (paddr != ehsec_pkg::STAT_ADDR);
  assign prdata  = prdata_q;

  // ============================================================
  // security and mode
  assign mask_eff    = rel_q ? mask_q : sec_mask_option;
  // bit meaningless without the mask option
  assign secure_live = mask_eff & ~cfg_q[ehsec_pkg::CFG_SECURITY_DISABLE_BIT];
  assign mode_live   = dec_mode(mode_select_b, mode_select_a, secure_live);

  // straps caught on the first edge after release, then frozen
  always_comb begin
    rel_d  = 1'b1;
    mask_d = rel_q ? mask_q : sec_mask_option;
    mode_d = rel_q ? mode_q : mode_live;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_q  <= 1'b0;
      mask_q <= 1'b0;
      mode_q <= ehsec_pkg::MODE_SCHIP;
    end else begin
      rel_q  <= rel_d;
      mask_q <= mask_d;
      mode_q <= mode_d;
    end
  end

  // ============================================================
  // program control, config byte and high voltage timer
  assign hv_on   = ctl_q[ehsec_pkg::CTL_PGM] & ctl_q[ehsec_pkg::CTL_LAT];
  assign hv_done = hv_on & (tmr_q == TMR_END);

  always_comb begin
    ctl_d    = ctl_q;
    cfg_d    = cfg_q;
    lat_d    = lat_q;
    tmr_d    = (hv_on && !hv_done) ? tmr_q + TMR_W_L'(1) : '0;  // restart each period
    prdata_d = prdata_q;
    // control write: voltage bit only with latch already set
    if (wr_acc && paddr == ehsec_pkg::CTL_ADDR) begin
      ctl_d = pwdata[7:0] & ehsec_pkg::CTL_MASK;
      if (!ctl_q[ehsec_pkg::CTL_LAT]) begin
        ctl_d[ehsec_pkg::CTL_PGM] = 1'b0;
      end
    end
    // config write while latched with voltage off captures the data, any value for erase
    if (wr_acc && paddr == ehsec_pkg::CFG_ADDR && ctl_q[ehsec_pkg::CTL_LAT] && !hv_on) begin
      lat_d = pwdata[7:0];
    end
    // end of the high voltage period commits the operation
    if (hv_done) begin
      if (ctl_q[ehsec_pkg::CTL_ERASE]) begin
        // bulk always reaches config; byte only where the variant allows it
        if ((!ctl_q[ehsec_pkg::CTL_BYTE] && !ctl_q[ehsec_pkg::CTL_ROW]) ||
            (ctl_q[ehsec_pkg::CTL_BYTE] && CFG_BYTE_ERASE)) begin
          cfg_d = ehsec_pkg::CFG_ERASED;
        end
      end else begin
        cfg_d = cfg_q & lat_d;
      end
    end
    // boot wipe erases config once storage is clean
    if (wst_q == ehsec_pkg::WP_CFG) begin
      cfg_d = ehsec_pkg::CFG_ERASED;
    end
    // read data registered in the setup phase
    if (rd_set) begin
      unique case (paddr)
        ehsec_pkg::CTL_ADDR:  prdata_d = {24'h000000, ctl_q};
        ehsec_pkg::CFG_ADDR:  prdata_d = {24'h000000, cfg_q};
        ehsec_pkg::STAT_ADDR: prdata_d = {26'h0000000, mask_q, (wst_q == ehsec_pkg::WP_DONE),
                                          mode_q, hv_on, secure_live};
        default:              prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q    <= ehsec_pkg::CTL_RST;
      lat_q    <= ehsec_pkg::CFG_ERASED;
      tmr_q    <= '0;
      prdata_q <= 32'h00000000;
    end else begin
      ctl_q    <= ctl_d;
      lat_q    <= lat_d;
      tmr_q    <= tmr_d;
      prdata_q <= prdata_d;
    end
  end

  // config byte lives in eeprom: no reset, so security survives a reset
  always_ff @(posedge pclk) begin
    cfg_q <= cfg_d;
  end

  // ============================================================
  // boot wipe: fill, verify, repeat on any mismatch, then erase config
  always_comb begin
    wst_d = wst_q;
    wad_d = wad_q;
    chk_d = 1'b0;
    tail_d = 1'b0;
    bad_d = bad_q;
    unique case (wst_q)
      ehsec_pkg::WP_IDLE: begin
        // only a secured bootstrap start wipes; plain bootstrap skips it
        if (rel_q && mode_q == ehsec_pkg::MODE_BOOT) begin
          wst_d = secure_live ? ehsec_pkg::WP_FILL : ehsec_pkg::WP_DONE;
        end
      end
      ehsec_pkg::WP_FILL: begin
        wad_d = wad_q + 1'b1;
        if (wad_q == WAD_END) begin
          wad_d = '0;
          bad_d = 1'b0;
          wst_d = ehsec_pkg::WP_VERIFY;
        end
      end
      ehsec_pkg::WP_VERIFY: begin
        // address stepping stops at the end; one tail cycle checks the last word
        chk_d  = !tail_q;
        tail_d = (wad_q == WAD_END) && !tail_q;
        if (wad_q != WAD_END) begin
          wad_d = wad_q + 1'b1;
        end
        if (chk_q && mif.rdata != ehsec_pkg::FILL_VAL) begin
          bad_d = 1'b1;
        end
        if (tail_q) begin
          wad_d = '0;
          wst_d = (bad_d) ? ehsec_pkg::WP_FILL : ehsec_pkg::WP_CFG;
        end
      end
      ehsec_pkg::WP_CFG:  wst_d = ehsec_pkg::WP_DONE;
      ehsec_pkg::WP_DONE: wst_d = ehsec_pkg::WP_DONE;
      default:            wst_d = ehsec_pkg::WP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst_q <= ehsec_pkg::WP_IDLE;
      wad_q <= '0;
      chk_q <= 1'b0;
      tail_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      wst_q <= wst_d;
      wad_q <= wad_d;
      chk_q <= chk_d;
      tail_q <= tail_d;
      bad_q <= bad_d;
    end
  end

  assign mif.we    = (wst_q == ehsec_pkg::WP_FILL);
  assign mif.addr  = wad_q;
  assign mif.wdata = ehsec_pkg::FILL_VAL;

  ehsec_mem u_mem (
    .pclk (pclk),
    .port (mif.mem)
  );

  // ============================================================
  // strobe pin: output only in unsecured expanded mode, else input
  assign strobe_in_or_addr_strobe_oe = (rel_q ? mode_q : mode_live) == ehsec_pkg::MODE_EXP;
  assign strobe_in_or_addr_strobe_o  = strobe_in_or_addr_strobe_oe & core_addr_strobe;
  assign strobe_a_capt = ~strobe_in_or_addr_strobe_oe & strobe_in_or_addr_strobe_i;
  assign op_mode       = mode_q;
  assign secure        = secure_live;
  assign boot_ready    = (wst_q == ehsec_pkg::WP_DONE);

  // ============================================================
  // assertions
  a_pgm_needs_latch: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == ehsec_pkg::CTL_ADDR && !ctl_q[ehsec_pkg::CTL_LAT] |=> !ctl_q[ehsec_pkg::CTL_PGM])
    else $error("voltage enable set without latch");
  a_mask_gates_sec: assert property (@(posedge pclk) disable iff (!presetn)
    rel_q && !mask_q |-> !secure)
    else $error("secure without mask option");
  a_security_disable_bit_engages: assert property (@(posedge pclk) disable iff (!presetn)
    rel_q && mask_q && !cfg_q[ehsec_pkg::CFG_SECURITY_DISABLE_BIT] |-> secure)
    else $error("security not engaged");
  a_secure_no_exp: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rel_q) && $past(secure_live) |-> !mode_q[0])
    else $error("mode a not forced low when secure");
  a_boot_select: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !rel_q && !mode_select_b && (!mode_select_a || secure_live) |=> mode_q == ehsec_pkg::MODE_BOOT)
    else $error("bootstrap not selected");
  a_strobe_input: assert property (@(posedge pclk) disable iff (!presetn)
    rel_q && mode_q != ehsec_pkg::MODE_EXP |-> !strobe_in_or_addr_strobe_oe)
    else $error("strobe driven outside expanded mode");
  a_fill_ones: assert property (@(posedge pclk) disable iff (!presetn)
    wst_q == ehsec_pkg::WP_FILL |-> mif.we && mif.wdata == 8'hff)
    else $error("fill value wrong");
  a_cfg_erase_end: assert property (@(posedge pclk) disable iff (!presetn)
    wst_q == ehsec_pkg::WP_CFG |=> cfg_q == 8'hff && boot_ready && !secure)
    else $error("config not erased after wipe");
  a_row_keeps_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    hv_done && ctl_q[ehsec_pkg::CTL_ERASE] && ctl_q[ehsec_pkg::CTL_ROW] && !ctl_q[ehsec_pkg::CTL_BYTE]
    && wst_q != ehsec_pkg::WP_CFG |=> $stable(cfg_q))
    else $error("row erase touched config");
  a_verify_ends: assert property (@(posedge pclk) disable iff (!presetn)
    wst_q == ehsec_pkg::WP_VERIFY && tail_q |=> wst_q != ehsec_pkg::WP_VERIFY)
    else $error("verify pass did not end after last word");
  a_boot_plain_done: assert property (@(posedge pclk) disable iff (!presetn)
    rel_q && wst_q == ehsec_pkg::WP_IDLE && mode_q == ehsec_pkg::MODE_BOOT && !secure_live |=> boot_ready)
    else $error("plain bootstrap not ready");
  a_strobe_exp_out: assert property (@(posedge pclk) disable iff (!presetn)
    rel_q && mode_q == ehsec_pkg::MODE_EXP |-> strobe_in_or_addr_strobe_oe
    && strobe_in_or_addr_strobe_o == core_addr_strobe)
    else $error("address strobe not driven in expanded mode");
endmodule : ehsec_core

// *** hdl/ehsec_pkg.sv ***
// ============================================================
// shared constants for the config byte and security block
package ehsec_pkg;
  // clock and program/erase timing
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned PROG_TIME_MS = 10;
  // whole cycles of high voltage per program or erase
  localparam int unsigned PROG_CYC     = (CLK_HZ / 1000) * PROG_TIME_MS;
  localparam int unsigned TMR_W        = 20;

  // register indices; the byte address is four times the index
  localparam logic [15:0] CTL_IDX  = 16'h103b;
  localparam logic [15:0] STAT_IDX = 16'h103c;
  localparam logic [15:0] CFG_IDX  = 16'h103f;
  localparam logic [15:0] CTL_ADDR  = 16'(CTL_IDX << 2);
  localparam logic [15:0] STAT_ADDR = 16'(STAT_IDX << 2);
  localparam logic [15:0] CFG_ADDR  = 16'(CFG_IDX << 2);

  // program control fields
  localparam int unsigned CTL_PGM   = 0;
  localparam int unsigned CTL_LAT   = 1;
  localparam int unsigned CTL_ERASE = 2;
  localparam int unsigned CTL_ROW   = 3;
  localparam int unsigned CTL_BYTE  = 4;
  localparam logic [7:0]  CTL_MASK  = 8'h1f;
  localparam logic [7:0]  CTL_RST   = 8'h00;

  // config byte fields and values
  localparam int unsigned CFG_SECURITY_DISABLE_BIT  = 3;
  localparam logic [7:0]  CFG_RST    = 8'h0f;
  localparam logic [7:0]  CFG_ERASED = 8'hff;

  // status fields
  localparam int unsigned ST_SECURE = 0;
  localparam int unsigned ST_BUSY   = 1;
  localparam int unsigned ST_MODE   = 2;
  localparam int unsigned ST_WIPED  = 4;
  localparam int unsigned ST_MASK   = 5;

  // wiped storage: array plus ram, filled with this value
  localparam int unsigned MEM_DEPTH = 768;
  localparam int unsigned MEM_AW    = 10;
  localparam logic [7:0]  FILL_VAL  = 8'hff;

  // operating mode, coded as {mode_select_b, mode_select_a}
  typedef enum logic [1:0] {
    MODE_BOOT  = 2'b00,
    MODE_TEST  = 2'b01,
    MODE_SCHIP = 2'b10,
    MODE_EXP   = 2'b11
  } ehsec_mode_t;

  // boot wipe sequencer
  typedef enum logic [2:0] {
    WP_IDLE   = 3'b000,
    WP_FILL   = 3'b001,
    WP_VERIFY = 3'b011,
    WP_CFG    = 3'b010,
    WP_DONE   = 3'b110
  } ehsec_wipe_t;
endpackage : ehsec_pkg

// *** hdl/ehsec_mem_if.sv ***
`timescale 1ns/100ps
// ============================================================
// port between the wipe sequencer and the storage it clears
interface ehsec_mem_if;
  logic                        we;     // write strobe
  logic [ehsec_pkg::MEM_AW-1:0] addr;  // word address
  logic [7:0]                  wdata;  // write data
  logic [7:0]                  rdata;  // registered read data
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : ehsec_mem_if

// *** hdl/ehsec_mem.sv ***
`timescale 1ns/100ps
// ============================================================
// single port byte store, read data one cycle after the address
module ehsec_mem (
  // clock
  input wire logic pclk,
  // access port
  ehsec_mem_if.mem port
);
  logic [7:0] store_q [ehsec_pkg::MEM_DEPTH];  // contents, no reset: large array
  logic [7:0] rdata_q;                          // registered read data

  // read first, returns the old word: a verify never runs beside a fill
  always_ff @(posedge pclk) begin
    if (port.we) begin
      store_q[port.addr] <= port.wdata;
    end
    rdata_q <= store_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule : ehsec_mem

// *** tb/ehsec_core_bench.sv ***
`timescale 1ns/100ps
// ============================================================
// bench for the config byte and security block
module ehsec_core_bench;
  localparam int unsigned PC = 20;  // short hv period keeps the run brief

  logic        pclk;        // bus clock
  logic        presetn;     // async reset, active low
  logic        psel;        // apb select
  logic        penable;     // apb enable
  logic        pwrite;      // apb direction
  logic [15:0] paddr;       // apb byte address
  logic [31:0] pwdata;      // apb write data
  logic [31:0] prdata;      // apb read data
  logic        pready;      // apb ready
  logic        pslverr;     // apb error
  logic        mode_select_a;
  logic        mode_select_b;
  logic        sec_mask_option;
  logic        pin_i;       // strobe pin as seen from outside
  logic        pin_o;       // strobe pin driven value
  logic        pin_oe;      // strobe pin enable
  logic        core_addr_strobe;
  logic        strobe_a_capt;
  logic [1:0]  op_mode;
  logic        secure;
  logic        boot_ready;
  int          err_count;   // mismatches
  int          checked;     // comparisons made

  ehsec_core #(.PROG_CYCLES(PC), .CFG_BYTE_ERASE(1'b0)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select_a(mode_select_a), .mode_select_b(mode_select_b), .sec_mask_option(sec_mask_option),
    .strobe_in_or_addr_strobe_i(pin_i), .strobe_in_or_addr_strobe_o(pin_o),
    .strobe_in_or_addr_strobe_oe(pin_oe), .core_addr_strobe(core_addr_strobe),
    .strobe_a_capt(strobe_a_capt), .op_mode(op_mode), .secure(secure), .boot_ready(boot_ready));

  // ============================================================
  // clock, time-zero values
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 16'h0000; pwdata = 32'h00000000; mode_select_a = 1'b0; mode_select_b = 1'b1;
    sec_mask_option = 1'b0; pin_i = 1'b0; core_addr_strobe = 1'b0; err_count = 0; checked = 0;
  end
  always #12.5 pclk = ~pclk;

  // ============================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0, "pready never came");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(a, 1'b1, d, rd, er);
  endtask : wr

  // read and compare a register
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic        er;
    apb(a, 1'b0, 8'h00, rd, er);
    chk(rd, exp, what);
    chk({31'h0, er}, 32'h0, "error flag on mapped read");
  endtask : rd_chk

  // latch step, config write, voltage on, hold past one period, clear
  task automatic prog_cfg(input logic [7:0] ctl, input logic [7:0] d);
    wr(ehsec_pkg::CTL_ADDR, ctl);
    wr(ehsec_pkg::CFG_ADDR, d);
    wr(ehsec_pkg::CTL_ADDR, ctl | 8'h01);
    repeat (PC + 4) @(posedge pclk);
    wr(ehsec_pkg::CTL_ADDR, 8'h00);
  endtask : prog_cfg

  // reset with given pins; checks the strobe enable while still in reset
  task automatic do_reset(input logic b, input logic a, input logic mask, input logic sec);
    @(posedge pclk);
    presetn <= 1'b0; mode_select_b <= b; mode_select_a <= a; sec_mask_option <= mask;
    repeat (10) @(posedge pclk);
    #1 chk({31'h0, pin_oe}, {31'h0, b & a & ~sec}, "strobe enable in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset

  // ============================================================
  // scenarios
  // each mode: latch, strobe pin use, boot flag, hold after release
  task automatic mode_case(input logic [1:0] m);
    do_reset(m[1], m[0], 1'b0, 1'b0);
    #1 chk({30'h0, op_mode}, {30'h0, m}, "latched mode");
    chk({31'h0, pin_oe}, {31'h0, m == 2'b11}, "strobe enable");
    chk({31'h0, boot_ready}, {31'h0, m == 2'b00}, "boot ready");
    rd_chk(ehsec_pkg::STAT_ADDR, {26'h0, 1'b0, m == 2'b00, m, 2'b00}, "status");
    @(posedge pclk);
    core_addr_strobe <= 1'b1; pin_i <= 1'b0; mode_select_a <= ~m[0]; mode_select_b <= ~m[1];
    @(posedge pclk);
    #1 chk({30'h0, op_mode}, {30'h0, m}, "mode held after pins move");
    if (m == 2'b11) chk({31'h0, pin_o}, 32'h1, "address strobe out");
    else chk({31'h0, strobe_a_capt}, 32'h0, "strobe a low");
    @(posedge pclk);
    core_addr_strobe <= 1'b0; pin_i <= 1'b1;
    @(posedge pclk);
    #1 if (m == 2'b11) chk({31'h0, pin_o}, 32'h0, "address strobe out low");
    else chk({31'h0, strobe_a_capt}, 32'h1, "strobe a high");
  endtask : mode_case

  // reset values, unmapped access, latch interlock
  task automatic regs_case;
    logic [31:0] rd;
    logic        er;
    do_reset(1'b1, 1'b0, 1'b1, 1'b0);
    rd_chk(ehsec_pkg::CTL_ADDR, 32'h00, "control reset");
    rd_chk(ehsec_pkg::CFG_ADDR, 32'h0f, "config reset");
    apb(16'h0000, 1'b0, 8'h00, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
    wr(ehsec_pkg::CTL_ADDR, 8'h01);
    rd_chk(ehsec_pkg::CTL_ADDR, 32'h00, "voltage without latch");
    wr(ehsec_pkg::CFG_ADDR, 8'h00);
    rd_chk(ehsec_pkg::CFG_ADDR, 32'h0f, "config write without latch");
  endtask : regs_case

  // erase then program, more zeros, refused erase kinds, security bit
  task automatic prog_case;
    prog_cfg(8'h06, 8'h5a);
    prog_cfg(8'h02, 8'h05);
    rd_chk(ehsec_pkg::CFG_ADDR, 32'h05, "erase then program");
    #1 chk({31'h0, secure}, 32'h1, "secured with option");
    wr(ehsec_pkg::CTL_ADDR, 8'h02);
    wr(ehsec_pkg::CFG_ADDR, 8'h04);
    wr(ehsec_pkg::CTL_ADDR, 8'h03);
    rd_chk(ehsec_pkg::CTL_ADDR, 32'h03, "voltage after latch");
    rd_chk(ehsec_pkg::STAT_ADDR, 32'h2b, "busy while voltage on");
    repeat (PC + 4) @(posedge pclk);
    wr(ehsec_pkg::CTL_ADDR, 8'h00);
    rd_chk(ehsec_pkg::CFG_ADDR, 32'h04, "more zeros");
    prog_cfg(8'h16, 8'h00);
    prog_cfg(8'h0e, 8'h00);
    rd_chk(ehsec_pkg::CFG_ADDR, 32'h04, "only bulk erases config");
    prog_cfg(8'h06, 8'h00);
    rd_chk(ehsec_pkg::CFG_ADDR, 32'hff, "bulk erase");
    #1 chk({31'h0, secure}, 32'h0, "disable bit set");
  endtask : prog_case

  // without the mask option the bit does nothing
  task automatic mask_case;
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    prog_cfg(8'h02, 8'h00);
    rd_chk(ehsec_pkg::CFG_ADDR, 32'h00, "config zero");
    #1 chk({31'h0, secure}, 32'h0, "no option no security");
  endtask : mask_case

  // secured reset reads mode a low; a secured bootstrap wipes and unlocks
  task automatic secure_case;
    int n;
    n = 0;
    do_reset(1'b1, 1'b1, 1'b1, 1'b1);
    #1 chk({30'h0, op_mode}, 32'h2, "secured mode forced single chip");
    chk({31'h0, pin_oe}, 32'h0, "strobe input while secured");
    chk({31'h0, secure}, 32'h1, "secure from kept config");
    do_reset(1'b0, 1'b0, 1'b1, 1'b1);
    #1 chk({31'h0, secure}, 32'h1, "still secure while wiping");
    chk({31'h0, boot_ready}, 32'h0, "download held during wipe");
    while (boot_ready !== 1'b1 && n < 4 * ehsec_pkg::MEM_DEPTH) begin
      @(posedge pclk);
      #1 n++;
    end
    chk({31'h0, boot_ready}, 32'h1, "wipe never finished");
    chk({31'h0, n >= 2 * ehsec_pkg::MEM_DEPTH - 4}, 32'h1, "wipe shorter than fill and verify");
    chk({31'h0, secure}, 32'h0, "wipe disengages security");
    rd_chk(ehsec_pkg::STAT_ADDR, 32'h30, "status after wipe");
    rd_chk(ehsec_pkg::CFG_ADDR, 32'hff, "config erased by wipe");
  endtask : secure_case

  // ============================================================
  // verdict and sequence
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    #(25 * 20000);
    err_count++;
    give_verdict();
  end

  initial begin
    for (int m = 0; m < 4; m++) begin
      mode_case(m[1:0]);
    end
    regs_case();
    prog_case();
    mask_case();
    secure_case();
    give_verdict();
  end
endmodule : ehsec_core_bench
